// [bench/ilcd_fetch_model.sv]
// ilcd_fetch_model: stand-in for the fetch unit that delivers further code bytes.
// assumes: one byte per byte_taken pulse, after lag idle cycles, while fetch_req is high.
`timescale 1ns/1ps
`default_nettype none
module ilcd_fetch_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // fetch handshake
    input wire logic fetch_req,
    input wire logic [3:0] lag,
    output logic byte_taken
);
    logic [3:0] wait_cnt;

    ////////////////////////////////////////////////////////////////////////
    // one-cycle pulse per byte; a slow memory stretches the gap.
    // the request is seen one edge late, but a pulse is never followed by
    // another in the next cycle, so no pulse trails the last byte
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wait_cnt <= 4'h0;
            byte_taken <= 1'b0;
        end
        else
        begin
            byte_taken <= fetch_req && !byte_taken && wait_cnt >= lag;
            wait_cnt <= (fetch_req && wait_cnt < lag) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

// [bench/instr_length_cycle_decode_test.sv]
// instr_length_cycle_decode_test: self-checking bench for ilcd_top.
// assumes: ilcd_pkg compiled first; a short machine cycle keeps the run brief.
`timescale 1ns/1ps
`default_nettype none
module instr_length_cycle_decode_test;
    import ilcd_pkg::*;
    localparam int CLKS_T = 2;
    logic clk, reset, instr_valid, byte_taken, instr_ready, fetch_req, dec_valid, dec_known;
    logic dec_bit_clear, dec_bad_form, busy, exec_done, hold_valid;
    logic [7:0] instr_opcode, instr_operand;
    logic [1:0] dec_bytes, dec_cycles;
    logic [3:0] lag;
    int err_total, total_checks;

    ////////////////////////////////////////////////////////////////////////
    // design and fetch unit model
    ilcd_top #(.CLKS(CLKS_T), .WORK_ADDR(WORK_REG_ADDR)) DUT (.clk(clk), .reset(reset),
        .instr_valid(instr_valid), .instr_opcode(instr_opcode), .instr_operand(instr_operand),
        .instr_ready(instr_ready), .fetch_req(fetch_req), .byte_taken(byte_taken),
        .dec_valid(dec_valid), .dec_known(dec_known), .dec_bytes(dec_bytes), .dec_cycles(dec_cycles),
        .dec_bit_clear(dec_bit_clear), .dec_bad_form(dec_bad_form), .busy(busy), .exec_done(exec_done));
    ilcd_fetch_model fetch (.clk(clk), .reset(reset), .fetch_req(fetch_req), .lag(lag),
        .byte_taken(byte_taken));

    // clock at 50 MHz
    always #10 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    // reporting
    task automatic check(input bit good, input string msg);
        total_checks++;
        if (!good)
        begin
            err_total++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk_idle();
        check(instr_ready === 1'b1 && busy === 1'b0 && fetch_req === 1'b0 && dec_valid === 1'b0
            && exec_done === 1'b0 && dec_bytes === 2'h0 && dec_cycles === 2'h0, "reset values");
    endtask

    // one instruction: decode, byte count and execution time from the last byte
    task automatic run_op(input logic [7:0] op, input logic [7:0] opnd, input logic [1:0] eb,
        input logic [1:0] ec, input logic kn, input logic bc, input logic bad);
        int k;
        int last;
        int got;
        @(posedge clk);
        #1;
        instr_valid = 1'b1;
        instr_opcode = op;
        instr_operand = opnd;
        @(posedge clk);
        #1;
        // while held, a changed opcode must be refused as long as busy
        instr_valid = hold_valid;
        instr_opcode = ~op;
        check(dec_valid === 1'b1 && dec_known === kn && dec_bytes === eb && dec_cycles === ec
            && dec_bit_clear === bc && dec_bad_form === bad && fetch_req === (eb > 2'h1) && busy === 1'b1, "decode");
        k = 1;
        last = 0;
        got = 0;
        while (exec_done !== 1'b1 && k < 60)
        begin
            if (byte_taken === 1'b1 && fetch_req === 1'b1)
            begin
                got++;
                last = k;
            end
            @(posedge clk);
            #1;
            k++;
        end
        instr_valid = 1'b0;
        check(got == eb - 1 && k - last == ec * CLKS_T + 1, "fetch count or timing");
        check(dec_valid === 1'b0 && dec_bytes === eb && fetch_req === 1'b0, "held result");
    endtask

    task automatic run_set(input logic [7:0] ops[], input logic [1:0] eb, input logic [1:0] ec);
        for (int i = 0; i < ops.size(); i++)
            run_op(ops[i], 8'h00, eb, ec, 1'b1, 1'b0, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_transfer();
        run_set('{8'hE8, 8'hEF, 8'hE6, 8'hE7}, 2'h1, 2'h1);
        run_set('{8'hE5, 8'h74}, 2'h2, 2'h1);
        run_set('{8'hF8}, 2'h1, 2'h1);
        run_set('{8'h78}, 2'h2, 2'h1);
        run_set('{8'hA8, 8'hAF}, 2'h2, 2'h2);
        run_set('{8'hF5}, 2'h2, 2'h1);
        run_set('{8'h88, 8'h86, 8'h87}, 2'h2, 2'h2);
        run_set('{8'h85, 8'h75}, 2'h3, 2'h2);
        run_set('{8'hF6, 8'hF7}, 2'h1, 2'h1);
        run_set('{8'hA6}, 2'h2, 2'h2);
        run_set('{8'h76}, 2'h2, 2'h1);
        run_set('{8'h90}, 2'h3, 2'h2);
        run_set('{8'h93, 8'h83}, 2'h1, 2'h2);
        run_set('{8'hE2, 8'hE3, 8'hE0, 8'hF2, 8'hF3, 8'hF0}, 2'h1, 2'h2);
        run_set('{8'hC0, 8'hD0}, 2'h2, 2'h2);
        run_set('{8'hC8, 8'hC6}, 2'h1, 2'h1);
        run_set('{8'hC5}, 2'h2, 2'h1);
        run_set('{8'hD6, 8'hD7}, 2'h1, 2'h1);
        $display("test transfer done");
    endtask

    task automatic t_bool_branch();
        run_set('{8'h82, 8'hB0, 8'h72, 8'hA0}, 2'h2, 2'h2);
        run_set('{8'hA2}, 2'h2, 2'h1);
        run_set('{8'h92}, 2'h2, 2'h2);
        run_set('{8'h73}, 2'h1, 2'h2);
        run_set('{8'h60, 8'h70, 8'h40, 8'h50}, 2'h2, 2'h2);
        // slow fetch unit for the long forms
        lag = 4'h3;
        run_set('{8'h20, 8'h30}, 2'h3, 2'h2);
        run_op(8'h10, 8'h00, 2'h3, 2'h2, 1'b1, 1'b1, 1'b0);
        run_set('{8'hB5, 8'hB4, 8'hB6, 8'hB7, 8'hB8, 8'hBF}, 2'h3, 2'h2);
        run_set('{8'hD8, 8'hDF}, 2'h2, 2'h2);
        run_set('{8'hD5}, 2'h3, 2'h2);
        lag = 4'h0;
        $display("test boolean and branch done");
    endtask

    // invalid self-copy, an opcode outside the groups, and a held request
    task automatic t_odd_forms();
        hold_valid = 1'b1;
        run_op(8'hE5, WORK_REG_ADDR, 2'h2, 2'h1, 1'b1, 1'b0, 1'b1);
        hold_valid = 1'b0;
        run_op(8'h24, 8'h00, 2'h1, 2'h1, 1'b0, 1'b0, 1'b0);
        $display("test odd forms done");
    endtask

    // reset in mid-fetch must return everything to idle
    task automatic t_midreset();
        lag = 4'h3;
        @(posedge clk);
        #1;
        instr_valid = 1'b1;
        instr_opcode = 8'h85;
        @(posedge clk);
        #1;
        instr_valid = 1'b0;
        @(posedge clk);
        #1;
        reset = 1'b1;
        #1;
        chk_idle();
        @(posedge clk);
        #1;
        reset = 1'b0;
        lag = 4'h0;
        run_set('{8'hE8}, 2'h1, 2'h1);
        $display("test midreset done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial
    begin
        {clk, instr_valid, hold_valid, err_total, total_checks} = '0;
        reset = 1'b1;
        instr_opcode = 8'h00;
        instr_operand = 8'h00;
        lag = 4'h0;
        repeat (4) @(posedge clk);
        #1;
        chk_idle();
        reset = 1'b0;
        t_transfer();
        t_bool_branch();
        t_odd_forms();
        t_midreset();
        end_sim();
    end

    initial
    begin
        #200000;
        err_total++;
        end_sim();
    end
endmodule
`default_nettype wire

// [verilog/ilcd_down_count.sv]
// ilcd_down_count: loadable down counter for bytes or machine cycles.
// assumes: load and step never both matter; load wins.
`timescale 1ns/1ps
`default_nettype none
module ilcd_down_count #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // control
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic step,
    // state
    output logic [W-1:0] count
);
    logic [W-1:0] next_count;

    // load has priority so a new instruction never inherits a stale count
    always_comb
    begin
        next_count = count;
        if (load)
            next_count = load_val;
        else if (step)
            next_count = count - W'(1);
    end

    // register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            count <= '0;
        else
            count <= next_count;
    end
endmodule
`default_nettype wire

// [verilog/ilcd_mcycle_div.sv]
// ilcd_mcycle_div: machine-cycle enable divider, one pulse every CLKS clocks.
// assumes: restart realigns the phase so a cycle count is exact.
`timescale 1ns/1ps
`default_nettype none
module ilcd_mcycle_div #(
    parameter int CLKS = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // control
    input wire logic restart,
    // enable pulse
    output logic tick
);
    localparam int W = $clog2(CLKS + 1);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    // wrap at CLKS-1; restart starts a fresh machine cycle
    always_comb
    begin
        next_cnt = cnt + W'(1);
        if (restart || cnt == W'(CLKS - 1))
            next_cnt = '0;
    end

    assign tick = (cnt == W'(CLKS - 1));

    // register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            cnt <= '0;
        else
            cnt <= next_cnt;
    end
endmodule
`default_nettype wire

// [verilog/ilcd_pkg.sv]
// ilcd_pkg: opcodes, code lengths, machine-cycle counts, state codes and
// the decode record shared by the length and cycle decoder.
// assumes: one 8-bit opcode space and one code byte per fetch transfer.
`default_nettype none
package ilcd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // code lengths in bytes and execution times in machine cycles
    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_3 = 2'h3;
    localparam logic [1:0] CYC_1 = 2'h1;
    localparam logic [1:0] CYC_2 = 2'h2;
    // clocks per machine cycle, default of the top-level parameter
    localparam int MCYCLE_CLKS = 6;
    // direct address of the main work register
    localparam logic [7:0] WORK_REG_ADDR = 8'hE0;

    ////////////////////////////////////////////////////////////////////////
    // opcodes: *_BANK is the base of a group of eight, *_IND of a pair
    localparam logic [7:0] OP_COPY_A_BANK = 8'hE8;
    localparam logic [7:0] OP_COPY_A_DIR = 8'hE5;
    localparam logic [7:0] OP_COPY_A_IND = 8'hE6;
    localparam logic [7:0] OP_COPY_A_IMM = 8'h74;
    localparam logic [7:0] OP_COPY_BANK_A = 8'hF8;
    localparam logic [7:0] OP_COPY_BANK_DIR = 8'hA8;
    localparam logic [7:0] OP_COPY_BANK_IMM = 8'h78;
    localparam logic [7:0] OP_COPY_DIR_A = 8'hF5;
    localparam logic [7:0] OP_COPY_DIR_BANK = 8'h88;
    localparam logic [7:0] OP_COPY_DIR_DIR = 8'h85;
    localparam logic [7:0] OP_COPY_DIR_IND = 8'h86;
    localparam logic [7:0] OP_COPY_DIR_IMM = 8'h75;
    localparam logic [7:0] OP_COPY_IND_A = 8'hF6;
    localparam logic [7:0] OP_COPY_IND_DIR = 8'hA6;
    localparam logic [7:0] OP_COPY_IND_IMM = 8'h76;
    localparam logic [7:0] OP_POINTER_LOAD = 8'h90;
    localparam logic [7:0] OP_CODE_BY_PTR = 8'h93;
    localparam logic [7:0] OP_CODE_BY_IC = 8'h83;
    localparam logic [7:0] OP_XRAM_RD_IND = 8'hE2;
    localparam logic [7:0] OP_XRAM_RD_PTR = 8'hE0;
    localparam logic [7:0] OP_XRAM_WR_IND = 8'hF2;
    localparam logic [7:0] OP_XRAM_WR_PTR = 8'hF0;
    localparam logic [7:0] OP_STACK_PUT = 8'hC0;
    localparam logic [7:0] OP_STACK_GET = 8'hD0;
    localparam logic [7:0] OP_SWAP_BANK = 8'hC8;
    localparam logic [7:0] OP_SWAP_DIR = 8'hC5;
    localparam logic [7:0] OP_SWAP_IND = 8'hC6;
    localparam logic [7:0] OP_NIBBLE_IND = 8'hD6;
    localparam logic [7:0] OP_AND_C_BIT = 8'h82;
    localparam logic [7:0] OP_AND_C_NBIT = 8'hB0;
    localparam logic [7:0] OP_OR_C_BIT = 8'h72;
    localparam logic [7:0] OP_OR_C_NBIT = 8'hA0;
    localparam logic [7:0] OP_BIT_TO_C = 8'hA2;
    localparam logic [7:0] OP_C_TO_BIT = 8'h92;
    localparam logic [7:0] OP_IND_BRANCH = 8'h73;
    localparam logic [7:0] OP_BR_ZERO = 8'h60;
    localparam logic [7:0] OP_BR_NZERO = 8'h70;
    localparam logic [7:0] OP_BR_CARRY = 8'h40;
    localparam logic [7:0] OP_BR_NCARRY = 8'h50;
    localparam logic [7:0] OP_BR_BIT_HI = 8'h20;
    localparam logic [7:0] OP_BR_BIT_LO = 8'h30;
    localparam logic [7:0] OP_BR_BIT_CLEAR = 8'h10;
    localparam logic [7:0] OP_CMP_A_DIR = 8'hB5;
    localparam logic [7:0] OP_CMP_A_IMM = 8'hB4;
    localparam logic [7:0] OP_CMP_IND_IMM = 8'hB6;
    localparam logic [7:0] OP_CMP_BANK_IMM = 8'hB8;
    localparam logic [7:0] OP_COUNT_BANK = 8'hD8;
    localparam logic [7:0] OP_COUNT_DIR = 8'hD5;

    ////////////////////////////////////////////////////////////////////////
    // sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_FETCH = 4'h2,
        ST_EXEC = 4'h4,
        ST_DONE = 4'h8
    } ilcd_state_e;

    // decode record of one instruction
    typedef struct packed {
        logic known;
        logic bit_clear;
        logic [1:0] bytes;
        logic [1:0] cycles;
    } ilcd_info_s;

endpackage
`default_nettype wire

// [verilog/ilcd_top.sv]
// ilcd_top: code length and machine-cycle decoder with a small sequencer
// for the data-transfer, boolean and program-control groups.
// assumes: the fetch unit presents opcode and the next code byte together,
// then pulses byte_taken once for each code byte after the opcode, that next byte included.
//
// How it works
// - work register loads take one cycle; direct and immediate are two bytes
// - bank register writes: from work 1/1, immediate 2/1, direct 2/2
// - direct writes: work 2/1, register or indirect 2/2, else 3/2
// - indirect writes: work 1/1, direct 2/2, immediate 2/1
// - loading the data pointer is three bytes and two cycles
// - code byte reads into work register: one byte, two cycles
// - external RAM copies of either address width: one byte, two cycles
// - stack store and stack pull of a direct byte: two bytes, two cycles
// - swaps with work register take one cycle; only direct is two bytes
// - nibble swap with indirect RAM is one byte, one cycle
// - AND or OR of a bit into carry: two bytes, two cycles
// - bit into carry is 2/1; carry into bit is two bytes
// - indirect branch via data pointer: one byte, two cycles
// - zero and carry branches: two bytes, two cycles, taken or not
// - bit branches are 3/2; the clearing form also sets dec_bit_clear
// - compare-and-branch forms are three bytes, two cycles
// - count-down branch: two cycles, two bytes register, three direct
`timescale 1ns/1ps
`default_nettype none
module ilcd_top #(
    parameter int CLKS = ilcd_pkg::MCYCLE_CLKS,
    parameter logic [7:0] WORK_ADDR = ilcd_pkg::WORK_REG_ADDR
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // fetch unit
    input wire logic instr_valid,
    input wire logic [7:0] instr_opcode,
    input wire logic [7:0] instr_operand,
    output logic instr_ready,
    output logic fetch_req,
    input wire logic byte_taken,
    // decode result
    output logic dec_valid,
    output logic dec_known,
    output logic [1:0] dec_bytes,
    output logic [1:0] dec_cycles,
    output logic dec_bit_clear,
    output logic dec_bad_form,
    // sequencer
    output logic busy,
    output logic exec_done
);
    import ilcd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // decode table
    // opcode belongs to the group of eight bank-register forms
    function automatic logic in_bank(input logic [7:0] op, input logic [7:0] base);
        in_bank = (op[7:3] == base[7:3]);
    endfunction

    // opcode belongs to the pair of pointer-register forms
    function automatic logic in_pair(input logic [7:0] op, input logic [7:0] base);
        in_pair = (op[7:1] == base[7:1]);
    endfunction

    // known form with its length and cycle count
    function automatic ilcd_info_s form(input logic [1:0] len, input logic [1:0] cyc);
        form = '{known: 1'h1, bit_clear: 1'h0, bytes: len, cycles: cyc};
    endfunction

    // unlisted opcodes fall back to one byte, one cycle, marked unknown
    function automatic ilcd_info_s decode(input logic [7:0] op);
        ilcd_info_s d;
        d = '{known: 1'h0, bit_clear: 1'h0, bytes: LEN_1, cycles: CYC_1};
        if (in_bank(op, OP_COPY_A_BANK) || in_pair(op, OP_COPY_A_IND))
            d = form(LEN_1, CYC_1);
        else if (op == OP_COPY_A_DIR || op == OP_COPY_A_IMM)
            d = form(LEN_2, CYC_1);
        else if (in_bank(op, OP_COPY_BANK_A))
            d = form(LEN_1, CYC_1);
        else if (in_bank(op, OP_COPY_BANK_IMM))
            d = form(LEN_2, CYC_1);
        else if (in_bank(op, OP_COPY_BANK_DIR))
            d = form(LEN_2, CYC_2);
        else if (op == OP_COPY_DIR_A)
            d = form(LEN_2, CYC_1);
        else if (in_bank(op, OP_COPY_DIR_BANK) || in_pair(op, OP_COPY_DIR_IND))
            d = form(LEN_2, CYC_2);
        else if (op == OP_COPY_DIR_DIR || op == OP_COPY_DIR_IMM)
            d = form(LEN_3, CYC_2);
        else if (in_pair(op, OP_COPY_IND_A))
            d = form(LEN_1, CYC_1);
        else if (in_pair(op, OP_COPY_IND_DIR))
            d = form(LEN_2, CYC_2);
        else if (in_pair(op, OP_COPY_IND_IMM))
            d = form(LEN_2, CYC_1);
        else if (op == OP_POINTER_LOAD)
            d = form(LEN_3, CYC_2);
        else if (op == OP_CODE_BY_PTR || op == OP_CODE_BY_IC)
            d = form(LEN_1, CYC_2);
        else if (in_pair(op, OP_XRAM_RD_IND) || in_pair(op, OP_XRAM_WR_IND))
            d = form(LEN_1, CYC_2);
        else if (op == OP_XRAM_RD_PTR || op == OP_XRAM_WR_PTR)
            d = form(LEN_1, CYC_2);
        else if (op == OP_STACK_PUT || op == OP_STACK_GET)
            d = form(LEN_2, CYC_2);
        else if (in_bank(op, OP_SWAP_BANK) || in_pair(op, OP_SWAP_IND))
            d = form(LEN_1, CYC_1);
        else if (op == OP_SWAP_DIR)
            d = form(LEN_2, CYC_1);
        else if (in_pair(op, OP_NIBBLE_IND))
            d = form(LEN_1, CYC_1);
        else if (op == OP_AND_C_BIT || op == OP_AND_C_NBIT || op == OP_OR_C_BIT || op == OP_OR_C_NBIT)
            d = form(LEN_2, CYC_2);
        else if (op == OP_BIT_TO_C)
            d = form(LEN_2, CYC_1);
        else if (op == OP_C_TO_BIT)
            d = form(LEN_2, CYC_2);
        else if (op == OP_IND_BRANCH)
            d = form(LEN_1, CYC_2);
        else if (op == OP_BR_ZERO || op == OP_BR_NZERO || op == OP_BR_CARRY || op == OP_BR_NCARRY)
            d = form(LEN_2, CYC_2);
        else if (op == OP_BR_BIT_HI || op == OP_BR_BIT_LO || op == OP_BR_BIT_CLEAR)
        begin
            d = form(LEN_3, CYC_2);
            d.bit_clear = (op == OP_BR_BIT_CLEAR);
        end
        else if (op == OP_CMP_A_DIR || op == OP_CMP_A_IMM)
            d = form(LEN_3, CYC_2);
        else if (in_bank(op, OP_CMP_BANK_IMM) || in_pair(op, OP_CMP_IND_IMM))
            d = form(LEN_3, CYC_2);
        else if (in_bank(op, OP_COUNT_BANK))
            d = form(LEN_2, CYC_2);
        else if (op == OP_COUNT_DIR)
            d = form(LEN_3, CYC_2);
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // declarations
    ilcd_state_e state, next_state;
    ilcd_info_s info, next_info;
    ilcd_info_s dec_now;
    logic [7:0] op_q, next_op_q;
    logic bad_q, next_bad_q;
    logic valid_q, next_valid_q;
    logic byte_load, cyc_load, mcyc_tick;
    logic [1:0] byte_cnt, cyc_cnt, cyc_load_val;

    assign dec_now = decode(instr_opcode);
    assign cyc_load_val = (state == ST_IDLE) ? dec_now.cycles : info.cycles;

    ////////////////////////////////////////////////////////////////////////
    // counters: bytes still to fetch, machine cycles still to spend
    ilcd_down_count #(.W(2)) u_byte_cnt (
        .clk(clk),
        .reset(reset),
        .load(byte_load),
        .load_val(2'(dec_now.bytes - LEN_1)),
        .step(state == ST_FETCH && byte_taken),
        .count(byte_cnt)
    );

    ilcd_down_count #(.W(2)) u_cyc_cnt (
        .clk(clk),
        .reset(reset),
        .load(cyc_load),
        .load_val(cyc_load_val),
        .step(state == ST_EXEC && mcyc_tick),
        .count(cyc_cnt)
    );

    // restarted on entry to execution so each count is whole machine cycles
    ilcd_mcycle_div #(.CLKS(CLKS)) u_div (
        .clk(clk),
        .reset(reset),
        .restart(cyc_load),
        .tick(mcyc_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer: take opcode, fetch the rest, spend the cycles

    always_comb
    begin
        next_state = state;
        next_info = info;
        next_op_q = op_q;
        next_bad_q = bad_q;
        next_valid_q = 1'h0;
        byte_load = 1'h0;
        cyc_load = 1'h0;
        case (state)
            ST_IDLE:
            begin
                if (instr_valid)
                begin
                    next_info = dec_now;
                    next_op_q = instr_opcode;
                    // the core does not execute this form, so flag it
                    next_bad_q = (instr_opcode == OP_COPY_A_DIR) && (instr_operand == WORK_ADDR);
                    next_valid_q = 1'h1;
                    if (dec_now.bytes == LEN_1)
                    begin
                        next_state = ST_EXEC;
                        cyc_load = 1'h1;
                    end
                    else
                    begin
                        next_state = ST_FETCH;
                        byte_load = 1'h1;
                    end
                end
            end
            ST_FETCH:
            begin
                if (byte_taken && byte_cnt == LEN_1)
                begin
                    next_state = ST_EXEC;
                    cyc_load = 1'h1;
                end
            end
            ST_EXEC:
            begin
                if (mcyc_tick && cyc_cnt == CYC_1)
                    next_state = ST_DONE;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    // register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state <= ST_IDLE;
            info <= '0;
            op_q <= '0;
            bad_q <= 1'h0;
            valid_q <= 1'h0;
        end
        else
        begin
            state <= next_state;
            info <= next_info;
            op_q <= next_op_q;
            bad_q <= next_bad_q;
            valid_q <= next_valid_q;
        end
    end

    // handshakes are decoded from state; data comes from flops
    assign instr_ready = (state == ST_IDLE);
    assign fetch_req = (state == ST_FETCH);
    assign busy = (state != ST_IDLE);
    assign exec_done = (state == ST_DONE);
    assign dec_valid = valid_q;
    assign dec_known = info.known;
    assign dec_bytes = info.bytes;
    assign dec_cycles = info.cycles;
    assign dec_bit_clear = info.bit_clear;
    assign dec_bad_form = bad_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic [7:0] exec_clks, next_exec_clks;

    // clocks spent in execution, for the timing check only
    always_comb
    begin
        next_exec_clks = '0;
        if (state == ST_EXEC)
            next_exec_clks = exec_clks + 8'h01;
        else if (state == ST_DONE)
            next_exec_clks = exec_clks;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            exec_clks <= '0;
        else
            exec_clks <= next_exec_clks;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    load_direct_a: assert property (
        dec_valid && op_q == OP_COPY_A_DIR |-> dec_bytes == LEN_2 && dec_cycles == CYC_1)
        else $error("direct load length or time wrong");
    reg_from_dir_a: assert property (
        dec_valid && op_q[7:3] == OP_COPY_BANK_DIR[7:3] |-> dec_bytes == LEN_2 && dec_cycles == CYC_2)
        else $error("register from direct wrong");
    dir_to_dir_a: assert property (
        dec_valid && op_q == OP_COPY_DIR_DIR |-> dec_bytes == LEN_3 && dec_cycles == CYC_2)
        else $error("direct to direct wrong");
    ind_from_imm_a: assert property (
        dec_valid && op_q[7:1] == OP_COPY_IND_IMM[7:1] |-> dec_bytes == LEN_2 && dec_cycles == CYC_1)
        else $error("indirect from immediate wrong");
    pointer_load_a: assert property (
        instr_valid && instr_ready && instr_opcode == OP_POINTER_LOAD
        |=> dec_valid && fetch_req ##0 dec_bytes == LEN_3 && dec_cycles == CYC_2)
        else $error("pointer load wrong");
    xram_one_byte_a: assert property (
        instr_valid && instr_ready && instr_opcode == OP_XRAM_RD_PTR |=> !fetch_req && busy [*2])
        else $error("external copy fetched extra bytes");
    swap_dir_a: assert property (
        dec_valid && op_q == OP_SWAP_DIR |-> dec_bytes == LEN_2 && dec_cycles == CYC_1)
        else $error("direct swap wrong");
    bad_form_a: assert property (
        instr_valid && instr_ready && instr_opcode == OP_COPY_A_DIR && instr_operand == WORK_ADDR
        |=> dec_bad_form)
        else $error("self copy not flagged");
    carry_to_bit_a: assert property (
        dec_valid && op_q == OP_C_TO_BIT |-> dec_bytes == LEN_2 && dec_cycles == CYC_2)
        else $error("carry to bit wrong");
    bit_clear_a: assert property (
        dec_valid |-> dec_bit_clear == (op_q == OP_BR_BIT_CLEAR))
        else $error("bit clear flag wrong");
    exec_time_a: assert property (
        $rose(exec_done) |-> exec_clks == 8'(32'(dec_cycles) * CLKS))
        else $error("execution time wrong");
    fetch_hold_a: assert property (
        fetch_req && !byte_taken |=> fetch_req && $stable(dec_bytes))
        else $error("fetch request dropped");
    decode_pulse_a: assert property (
        instr_valid && instr_ready |=> dec_valid ##1 !dec_valid)
        else $error("decode pulse wrong");
endmodule
`default_nettype wire
